// file: verilog/scl_logger.sv
// Added by the designer: the register addresses and register access over Wishbone.
`default_nettype none
module scl_logger #(
	parameter int FAST_MIN_CYC = scl_pkg::FAST_MIN_NS / scl_pkg::CLK_NS,
	parameter int FAST_MAX_CYC = scl_pkg::FAST_MAX_NS / scl_pkg::CLK_NS,
	parameter int CONV_CYC = scl_pkg::CONV_NS / scl_pkg::CLK_NS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic gate_i,
	input wire logic [scl_pkg::NCH*scl_pkg::CW-1:0] cnt_i,
	output logic count_en_o,
	output logic rec_we_o,
	output logic [scl_pkg::AW-1:0] rec_addr_o,
	output logic [scl_pkg::NCH*scl_pkg::CW-1:0] rec_data_o
);
	// ----------------------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------------------
	localparam int IVW_L = scl_pkg::IVW; // interval counter width, declared before its use
	scl_pkg::scl_state_e state_r; // acquisition state
	scl_pkg::scl_state_e state_nxt; // next acquisition state
	logic diff_r; // difference recording selected
	logic pol_r; // gate active high when set
	logic [13:0] cur_r; // current record address
	logic [13:0] end_r; // end record address
	logic [31:0] on_us_r; // pacer on time
	logic [31:0] off_us_r; // pacer off time
	logic wb_req; // new bus request
	logic wb_wr; // register write this cycle
	logic [31:0] wmask; // byte lane mask
	logic [5:0] cmd; // command strobes
	logic gate_act; // gate after polarity
	logic gate_q_r; // gate one cycle ago
	logic gate_fall; // falling edge of active gate
	logic pacer_on; // pacer on phase
	logic pacer_end; // end of pacer on phase
	logic capture; // write a record this cycle
	logic start_any; // any start command
	logic count_en_nxt; // next counter enable
	logic [IVW_L-1:0] ival_r; // cycles since last capture
	logic fast_r; // a capture came in the fast band
	logic [31:0] conv_r; // conversion cycles remaining
	logic [1:0] stat_mode; // status mode code
	logic [31:0] rd_nxt; // read data mux
	logic [scl_pkg::CW-1:0] prev_r [scl_pkg::NCH]; // counts at previous capture
	logic [scl_pkg::CW-1:0] rec_r [scl_pkg::NCH]; // record being written

	// ----------------------------------------------------------------------------
	// wishbone slave, one wait-free answer a cycle after the request
	// ----------------------------------------------------------------------------
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_req && wb_we_i;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	// command strobes exist only for a write to the command word
	assign cmd = (wb_wr && wb_adr_i == scl_pkg::OFF_CMD) ? 6'(wb_dat_i & wmask) : 6'h00;
	assign start_any = cmd[scl_pkg::CMD_GATE] || cmd[scl_pkg::CMD_EDGE] ||
		cmd[scl_pkg::CMD_PACER];

	// ack drops in the cycle after it was given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	// status mode code from state
	always_comb begin
		unique case (state_r)
			scl_pkg::SCL_GATE: stat_mode = scl_pkg::STAT_GATE;
			scl_pkg::SCL_TIMER: stat_mode = scl_pkg::STAT_TIMER;
			scl_pkg::SCL_EDGE_WAIT, scl_pkg::SCL_EDGE_RUN: stat_mode = scl_pkg::STAT_EDGE;
			default: stat_mode = scl_pkg::STAT_OFF;
		endcase
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		rd_nxt = 32'h0;
		unique case (wb_adr_i)
			scl_pkg::OFF_MODE: rd_nxt = {8'h00, diff_r ? scl_pkg::INCREMENT_MODE_CODE :
				scl_pkg::RAW_MODE_CODE};
			scl_pkg::OFF_STATUS: begin
				rd_nxt[1:0] = stat_mode;
				rd_nxt[scl_pkg::STAT_CONV_BIT] = (conv_r != 32'h0);
			end
			scl_pkg::OFF_CUR: rd_nxt = {18'h0, cur_r};
			scl_pkg::OFF_END: rd_nxt = {18'h0, end_r};
			scl_pkg::OFF_ON: rd_nxt = on_us_r;
			scl_pkg::OFF_OFF: rd_nxt = off_us_r;
			scl_pkg::OFF_POL: rd_nxt = {31'h0, pol_r};
			default: rd_nxt = 32'h0;
		endcase
	end

	// read data register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else if (wb_req && !wb_we_i) begin
			wb_dat_o <= rd_nxt;
		end
	end

	// ----------------------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------------------
	// recording mode select
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			diff_r <= 1'b0;
		end else if (cmd[scl_pkg::CMD_DIFF]) begin
			diff_r <= 1'b1;
		end else if (cmd[scl_pkg::CMD_ACCUM]) begin
			diff_r <= 1'b0;
		end
	end

	// pacer durations and gate polarity
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			on_us_r <= scl_pkg::ON_RST;
			off_us_r <= scl_pkg::OFF_RST;
			pol_r <= scl_pkg::POL_RST;
		end else if (wb_wr) begin
			if (wb_adr_i == scl_pkg::OFF_ON) begin
				on_us_r <= (on_us_r & ~wmask) | (wb_dat_i & wmask);
			end
			if (wb_adr_i == scl_pkg::OFF_OFF) begin
				off_us_r <= (off_us_r & ~wmask) | (wb_dat_i & wmask);
			end
			if (wb_adr_i == scl_pkg::OFF_POL && wb_sel_i[0]) begin
				pol_r <= wb_dat_i[0];
			end
		end
	end

	// end address, clamped to the last slot
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			end_r <= scl_pkg::END_RST;
		end else if (wb_wr && wb_adr_i == scl_pkg::OFF_END && wb_sel_i[1:0] == 2'h3) begin
			end_r <= (wb_dat_i[13:0] > scl_pkg::ADDR_MAX) ? scl_pkg::ADDR_MAX :
				wb_dat_i[13:0];
		end
	end

	// current address: host write, or one step per record
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_r <= scl_pkg::CUR_RST;
		end else if (capture) begin
			cur_r <= cur_r + 14'h0001;
		end else if (wb_wr && wb_adr_i == scl_pkg::OFF_CUR && wb_sel_i[1:0] == 2'h3) begin
			cur_r <= (wb_dat_i[13:0] > scl_pkg::ADDR_MAX) ? scl_pkg::ADDR_MAX :
				wb_dat_i[13:0];
		end
	end

	// ----------------------------------------------------------------------------
	// gate conditioning and pacer
	// ----------------------------------------------------------------------------
	assign gate_act = pol_r ? gate_i : !gate_i;
	assign gate_fall = gate_q_r && !gate_act;

	// previous gate level for edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_q_r <= 1'b0;
		end else begin
			gate_q_r <= gate_act;
		end
	end

	// internal pacing clock runs only in timer mode
	scl_pacer u_pacer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(state_r == scl_pkg::SCL_TIMER),
		.on_us_i(on_us_r),
		.off_us_i(off_us_r),
		.on_o(pacer_on),
		.end_on_o(pacer_end)
	);

	// ----------------------------------------------------------------------------
	// acquisition state machine
	// ----------------------------------------------------------------------------
	// record instants per mode
	always_comb begin
		unique case (state_r)
			scl_pkg::SCL_GATE: capture = gate_fall;
			scl_pkg::SCL_EDGE_RUN: capture = gate_fall;
			scl_pkg::SCL_TIMER: capture = pacer_end;
			default: capture = 1'b0;
		endcase
		if (cmd[scl_pkg::CMD_STOP] || start_any) begin
			capture = 1'b0;
		end
	end

	// next state
	always_comb begin
		state_nxt = state_r;
		if (cmd[scl_pkg::CMD_STOP]) begin
			state_nxt = scl_pkg::SCL_IDLE;
		end else if (cmd[scl_pkg::CMD_GATE]) begin
			state_nxt = scl_pkg::SCL_GATE;
		end else if (cmd[scl_pkg::CMD_EDGE]) begin
			state_nxt = scl_pkg::SCL_EDGE_WAIT;
		end else if (cmd[scl_pkg::CMD_PACER]) begin
			state_nxt = scl_pkg::SCL_TIMER;
		end else if (state_r == scl_pkg::SCL_EDGE_WAIT && gate_fall) begin
			state_nxt = scl_pkg::SCL_EDGE_RUN;
		end else if (capture && (cur_r == end_r || cur_r >= scl_pkg::ADDR_MAX)) begin
			state_nxt = scl_pkg::SCL_IDLE;
		end
	end

	// counter enable for the next state
	always_comb begin
		unique case (state_nxt)
			scl_pkg::SCL_GATE: count_en_nxt = gate_act;
			scl_pkg::SCL_EDGE_RUN: count_en_nxt = 1'b1;
			scl_pkg::SCL_TIMER: count_en_nxt = pacer_on && gate_act;
			default: count_en_nxt = 1'b0;
		endcase
	end

	// state and counter enable registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= scl_pkg::SCL_IDLE;
			count_en_o <= 1'b0;
		end else begin
			state_r <= state_nxt;
			count_en_o <= count_en_nxt;
		end
	end

	// ----------------------------------------------------------------------------
	// record write port
	// ----------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rec_we_o <= 1'b0;
			rec_addr_o <= 14'h0000;
		end else begin
			rec_we_o <= capture;
			if (capture) begin
				rec_addr_o <= cur_r;
			end
		end
	end

	// per channel capture and difference
	for (genvar g = 0; g < scl_pkg::NCH; g++) begin : g_ch
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				prev_r[g] <= 32'h0;
			end else if (start_any || capture) begin
				prev_r[g] <= cnt_i[g*scl_pkg::CW +: scl_pkg::CW];
			end
		end
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				rec_r[g] <= 32'h0;
			end else if (capture) begin
				rec_r[g] <= diff_r ? cnt_i[g*scl_pkg::CW +: scl_pkg::CW] - prev_r[g] :
					cnt_i[g*scl_pkg::CW +: scl_pkg::CW];
			end
		end
		assign rec_data_o[g*scl_pkg::CW +: scl_pkg::CW] = rec_r[g];
	end

	// ----------------------------------------------------------------------------
	// background conversion status
	// ----------------------------------------------------------------------------
	// capture interval, saturating
	always_ff @(posedge clk_i) begin
		if (rst_i || start_any || capture) begin
			ival_r <= '0;
		end else if (ival_r != {IVW_L{1'b1}}) begin
			ival_r <= ival_r + 1'b1;
		end
	end

	// remember whether any capture fell in the fast band
	always_ff @(posedge clk_i) begin
		if (rst_i || start_any) begin
			fast_r <= 1'b0;
		end else if (capture && ival_r >= IVW_L'(FAST_MIN_CYC) &&
			ival_r < IVW_L'(FAST_MAX_CYC)) begin
			fast_r <= 1'b1;
		end
	end

	// conversion runs on after a fast acquisition ends
	always_ff @(posedge clk_i) begin
		if (rst_i || start_any) begin
			conv_r <= 32'h0;
		end else if (state_r != scl_pkg::SCL_IDLE && state_nxt == scl_pkg::SCL_IDLE &&
			(fast_r || capture && ival_r >= IVW_L'(FAST_MIN_CYC) &&
			ival_r < IVW_L'(FAST_MAX_CYC))) begin
			conv_r <= 32'(CONV_CYC);
		end else if (conv_r != 32'h0) begin
			conv_r <= conv_r - 32'h1;
		end
	end

	// ----------------------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_reset_accum_mode: assert property ($past(rst_i) |-> !diff_r)
		else $error("recording mode not accumulation after reset");
	a_stop_halts_all: assert property (cmd[scl_pkg::CMD_STOP] |=>
		state_r == scl_pkg::SCL_IDLE && !count_en_o && !rec_we_o ##1 !rec_we_o)
		else $error("stop did not halt acquisition");
	a_edge_wait_closed: assert property (state_r == scl_pkg::SCL_EDGE_WAIT |-> !count_en_o)
		else $error("counters open before first gate fall");
	a_edge_opens_fall: assert property (state_r == scl_pkg::SCL_EDGE_WAIT && gate_fall &&
		cmd == 6'h00 |=> state_r == scl_pkg::SCL_EDGE_RUN && count_en_o)
		else $error("edge mode did not open at fall");
	a_gate_level_count: assert property (state_r == scl_pkg::SCL_GATE &&
		$past(state_r) == scl_pkg::SCL_GATE |-> count_en_o == $past(gate_act))
		else $error("gate mode count enable not following gate");
	a_raw_record_value: assert property (rec_we_o && !$past(diff_r) |->
		rec_data_o[31:0] == $past(cnt_i[31:0]))
		else $error("raw record differs from counter");
	a_diff_record_value: assert property (rec_we_o && $past(diff_r) |->
		rec_data_o[31:0] == $past(cnt_i[31:0]) - $past(prev_r[0]))
		else $error("difference record wrong");
	a_addr_step_one: assert property (rec_we_o |-> cur_r == rec_addr_o + 14'h0001)
		else $error("current address did not advance by one");
	a_auto_stop_end: assert property (capture && cur_r == end_r |=>
		state_r == scl_pkg::SCL_IDLE ##1 !rec_we_o)
		else $error("no stop at end address");
	a_pacer_start_run: assert property (cmd[scl_pkg::CMD_PACER] && !cmd[scl_pkg::CMD_STOP] |=>
		state_r == scl_pkg::SCL_TIMER)
		else $error("pacer start not taken");
	a_idle_no_records: assert property (state_r == scl_pkg::SCL_IDLE |=> !rec_we_o)
		else $error("record written while idle");
endmodule
`default_nettype wire

// file: verilog/scl_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// shared constants of the count logger
// ----------------------------------------------------------------------------
package scl_pkg;
	// channel layout
	localparam int NCH = 8; // counter channels captured per record
	localparam int CW = 32; // bits per counter channel
	localparam int AW = 14; // record address width
	localparam logic [13:0] ADDR_MAX = 14'h270F; // last record slot
	// register byte offsets
	localparam logic [7:0] OFF_CMD = 8'h00; // write-only command strobes
	localparam logic [7:0] OFF_MODE = 8'h04; // recording mode code
	localparam logic [7:0] OFF_STATUS = 8'h08; // acquisition status
	localparam logic [7:0] OFF_CUR = 8'h0C; // current record address
	localparam logic [7:0] OFF_END = 8'h10; // end record address
	localparam logic [7:0] OFF_ON = 8'h14; // pacer on duration, us
	localparam logic [7:0] OFF_OFF = 8'h18; // pacer off duration, us
	localparam logic [7:0] OFF_POL = 8'h1C; // gate polarity
	// command bit positions
	localparam int CMD_ACCUM = 0; // select accumulation recording
	localparam int CMD_DIFF = 1; // select difference recording
	localparam int CMD_GATE = 2; // gate level start
	localparam int CMD_EDGE = 3; // gate edge start
	localparam int CMD_PACER = 4; // pacer start
	localparam int CMD_STOP = 5; // stop acquisition in any mode
	// recording mode answer codes, three ascii letters
	localparam logic [23:0] RAW_MODE_CODE = 24'h46554C;
	localparam logic [23:0] INCREMENT_MODE_CODE = 24'h444946;
	// status field layout and codes
	localparam int STAT_CONV_BIT = 4; // hex conversion in progress
	localparam logic [1:0] STAT_OFF = 2'h0; // no acquisition
	localparam logic [1:0] STAT_GATE = 2'h1; // gate level mode
	localparam logic [1:0] STAT_TIMER = 2'h2; // timer gate mode
	localparam logic [1:0] STAT_EDGE = 2'h3; // gate edge mode
	// values after reset
	localparam logic [13:0] CUR_RST = 14'h0000;
	localparam logic [13:0] END_RST = 14'h270F;
	localparam logic [31:0] ON_RST = 32'h00004E20;
	localparam logic [31:0] OFF_RST = 32'h00004E20;
	localparam logic POL_RST = 1'b1; // active high gate
	// timing
	localparam int CLK_NS = 8; // clock period
	localparam int US_NS = 1000; // one microsecond
	localparam int CYC_PER_US = US_NS / CLK_NS;
	localparam int OFF_ZERO_NS = 200; // off time for a zero setting
	localparam int OFF_ZERO_CYC = OFF_ZERO_NS / CLK_NS;
	localparam int FAST_MIN_NS = 1000000; // 1 ms
	localparam int FAST_MAX_NS = 10000000; // 10 ms
	localparam int CONV_NS = 1000000; // background conversion time
	localparam int IVW = 21; // interval counter width
	// acquisition states, gray along idle-gate-timer and edge path
	typedef enum logic [2:0] {
		SCL_IDLE = 3'h0,
		SCL_GATE = 3'h1,
		SCL_TIMER = 3'h3,
		SCL_EDGE_WAIT = 3'h2,
		SCL_EDGE_RUN = 3'h6
	} scl_state_e;
endpackage
`default_nettype wire

// file: verilog/scl_pacer.sv
`default_nettype none
// ----------------------------------------------------------------------------
// internal on/off pacing clock in microsecond steps
// ----------------------------------------------------------------------------
module scl_pacer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [31:0] on_us_i,
	input wire logic [31:0] off_us_i,
	output logic on_o,
	output logic end_on_o
);
	logic [6:0] cyc_r; // cycles within one microsecond
	logic [31:0] us_r; // microseconds elapsed in phase
	logic us_tick; // last cycle of a microsecond
	logic on_done; // on phase complete
	logic off_done; // off phase complete

	assign us_tick = (cyc_r == 7'(scl_pkg::CYC_PER_US - 1));
	// a zero on setting acts as one microsecond
	assign on_done = us_tick && ((us_r + 32'h1) >= on_us_i);
	// zero off setting gives the short fixed off time
	assign off_done = (off_us_i == 32'h0) ? (cyc_r == 7'(scl_pkg::OFF_ZERO_CYC - 1)) :
		(us_tick && ((us_r + 32'h1) >= off_us_i));

	// ----------------------------------------------------------------------------
	// phase and counters
	// ----------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			// idle: restart with a fresh on phase
			on_o <= 1'b0;
			end_on_o <= 1'b0;
			cyc_r <= 7'h00;
			us_r <= 32'h0;
		end else if (!on_o) begin
			end_on_o <= 1'b0;
			if (off_done || (us_r == 32'h0 && cyc_r == 7'h00 && !end_on_o)) begin
				// off finished, or first entry after run: open on phase
				on_o <= 1'b1;
				cyc_r <= 7'h00;
				us_r <= 32'h0;
			end else begin
				cyc_r <= us_tick ? 7'h00 : cyc_r + 7'h01;
				us_r <= us_tick ? us_r + 32'h1 : us_r;
			end
		end else if (on_done) begin
			// on finished: close and flag the capture
			on_o <= 1'b0;
			end_on_o <= 1'b1;
			// off phase counts from zero so it lasts the full time; end_on_o masks the entry test
			cyc_r <= 7'h00;
			us_r <= 32'h0;
		end else begin
			end_on_o <= 1'b0;
			cyc_r <= us_tick ? 7'h00 : cyc_r + 7'h01;
			us_r <= us_tick ? us_r + 32'h1 : us_r;
		end
	end
endmodule
`default_nettype wire

// file: testbench/scl_field_model.sv
`default_nettype none
// ----------------------------------------------------------------------------
// counter channels and gate source on the far side of the logger
// ----------------------------------------------------------------------------
module scl_field_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic count_en_i,
	input wire logic gate_lvl_i,
	output logic gate_o,
	output logic [scl_pkg::NCH*scl_pkg::CW-1:0] cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// gate line carries the level the bench commands, passed straight through in every run
	assign gate_o = gate_lvl_i;
	// channel g adds g+1 per enabled cycle, so channels never look alike
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_o <= '0;
		end else if (count_en_i) begin
			for (int g = 0; g < scl_pkg::NCH; g++) begin
				cnt_o[g*32 +: 32] <= cnt_o[g*32 +: 32] + 32'(g + 1);
			end
		end
	end
endmodule
`default_nettype wire

// file: testbench/test_synchronous_count_logger.sv
`default_nettype none
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module test_synchronous_count_logger;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------------------
	localparam int NB = scl_pkg::NCH * scl_pkg::CW;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, gate_lvl = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, q;
	wire logic [31:0] rdat;
	wire logic ack, count_en, rec_we, gate;
	wire logic [13:0] rec_addr;
	wire logic [NB-1:0] rec_data, cnt;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [NB-1:0] cnt_last; // counters as sampled at the previous edge
	logic [NB-1:0] cnt0; // counters when a start is issued, frozen while idle
	logic [13:0] rec_a[$];
	logic [NB-1:0] rec_d[$], rec_c[$];
	int rec_t[$];
	// ----------------------------------------------------------------------------
	// design, far side and clock
	// ----------------------------------------------------------------------------
	scl_logger #(.FAST_MIN_CYC(20), .FAST_MAX_CYC(200), .CONV_CYC(50)) DUT (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .gate_i(gate),
		.cnt_i(cnt), .count_en_o(count_en), .rec_we_o(rec_we), .rec_addr_o(rec_addr),
		.rec_data_o(rec_data));
	scl_field_model u_field (.clk_i(clk_i), .rst_i(rst_i), .count_en_i(count_en),
		.gate_lvl_i(gate_lvl), .gate_o(gate), .cnt_o(cnt));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// record monitor: keeps address, data, counters at capture and arrival cycle
	always @(posedge clk_i) begin
		if (rec_we === 1'b1) begin
			rec_a.push_back(rec_addr);
			rec_d.push_back(rec_data);
			rec_c.push_back(cnt_last);
			rec_t.push_back(cycles);
		end
		cnt_last = cnt;
	end
	// hang guard, well above the several hundred cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// ----------------------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------------------
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_xfer(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		wb_xfer(1'b0, a, 32'h0);
		`CHK(what, exp, q)
	endtask
	// one gate pulse; count enable is looked at late in the high phase
	task automatic pulse(input int hi, input int lo, input logic en);
		@(posedge clk_i);
		gate_lvl <= 1'b1;
		repeat (hi) @(posedge clk_i);
		`CHK("count enable", en, count_en)
		gate_lvl <= 1'b0;
		repeat (lo) @(posedge clk_i);
	endtask
	task automatic chk_rec(input int i, input logic [13:0] a, input logic [NB-1:0] exp);
		`CHK("record address", a, rec_a[i])
		`CHK("record data", exp, rec_d[i])
	endtask
	task automatic next_test(input string s);
		$display("test %s done, %0d comparisons", s, comparisons);
		rec_a.delete();
		rec_d.delete();
		rec_c.delete();
		rec_t.delete();
	endtask
	// per-channel present minus previous
	function automatic logic [NB-1:0] increment_mode_code(input logic [NB-1:0] a, input logic [NB-1:0] b);
		logic [NB-1:0] r;
		for (int g = 0; g < scl_pkg::NCH; g++) r[g*32 +: 32] = a[g*32 +: 32] - b[g*32 +: 32];
		return r;
	endfunction
	// ----------------------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(scl_pkg::OFF_MODE, {8'h00, scl_pkg::RAW_MODE_CODE}, "mode");
		rd_chk(scl_pkg::OFF_STATUS, 32'h0, "status");
		rd_chk(scl_pkg::OFF_CUR, 32'h0, "current");
		rd_chk(scl_pkg::OFF_END, 32'h270F, "end");
		rd_chk(scl_pkg::OFF_ON, 32'h4E20, "on");
		rd_chk(scl_pkg::OFF_OFF, 32'h4E20, "off");
		rd_chk(scl_pkg::OFF_POL, 32'h1, "polarity");
		rd_chk(8'h20, 32'h0, "unmapped");
		next_test("reset");
		// gate level, two slots then an extra fall after the end
		wr(scl_pkg::OFF_CUR, 32'h5);
		wr(scl_pkg::OFF_END, 32'h6);
		wr(scl_pkg::OFF_CMD, 32'h4);
		rd_chk(scl_pkg::OFF_STATUS, {30'h0, scl_pkg::STAT_GATE}, "status gate");
		pulse(8, 4, 1'b1);
		pulse(8, 4, 1'b1);
		pulse(8, 4, 1'b0);
		`CHK("records", 2, rec_a.size())
		chk_rec(0, 14'h5, rec_c[0]);
		chk_rec(1, 14'h6, rec_c[1]);
		rd_chk(scl_pkg::OFF_CUR, 32'h7, "current after");
		rd_chk(scl_pkg::OFF_STATUS, 32'h0, "status idle");
		next_test("gate level");
		// gate edge in difference recording
		wr(scl_pkg::OFF_CMD, 32'h2);
		rd_chk(scl_pkg::OFF_MODE, {8'h00, scl_pkg::INCREMENT_MODE_CODE}, "mode diff");
		wr(scl_pkg::OFF_CUR, 32'hA);
		wr(scl_pkg::OFF_END, 32'hB);
		cnt0 = cnt;
		wr(scl_pkg::OFF_CMD, 32'h8);
		rd_chk(scl_pkg::OFF_STATUS, {30'h0, scl_pkg::STAT_EDGE}, "status edge");
		pulse(8, 4, 1'b0);
		pulse(8, 4, 1'b1);
		pulse(8, 4, 1'b1);
		`CHK("records", 2, rec_a.size())
		chk_rec(0, 14'hA, increment_mode_code(rec_c[0], cnt0));
		chk_rec(1, 14'hB, increment_mode_code(rec_c[1], rec_c[0]));
		wr(scl_pkg::OFF_CMD, 32'h1);
		rd_chk(scl_pkg::OFF_MODE, {8'h00, scl_pkg::RAW_MODE_CODE}, "mode raw");
		next_test("gate edge");
		// pacer 1 us on, zero off; far under the advice, to keep the run brief
		wr(scl_pkg::OFF_ON, 32'h1);
		wr(scl_pkg::OFF_OFF, 32'h0);
		wr(scl_pkg::OFF_CUR, 32'h14);
		wr(scl_pkg::OFF_END, 32'h15);
		wr(scl_pkg::OFF_CMD, 32'h10);
		rd_chk(scl_pkg::OFF_STATUS, {30'h0, scl_pkg::STAT_TIMER}, "status timer");
		repeat (40) @(posedge clk_i);
		`CHK("count enable", 1'b0, count_en)
		gate_lvl <= 1'b1;
		repeat (40) @(posedge clk_i);
		`CHK("count enable", 1'b1, count_en)
		while (rec_a.size() < 2) @(posedge clk_i);
		chk_rec(0, 14'h14, rec_c[0]);
		chk_rec(1, 14'h15, rec_c[1]);
		`CHK("pacer period", scl_pkg::CYC_PER_US + scl_pkg::OFF_ZERO_CYC, rec_t[1] - rec_t[0])
		rd_chk(scl_pkg::OFF_STATUS, 32'h10, "status converting");
		repeat (60) @(posedge clk_i);
		rd_chk(scl_pkg::OFF_STATUS, 32'h0, "status done");
		gate_lvl <= 1'b0;
		next_test("pacer");
		// stop in the middle of a gate pulse
		wr(scl_pkg::OFF_END, 32'h28);
		wr(scl_pkg::OFF_CMD, 32'h4);
		gate_lvl <= 1'b1;
		repeat (5) @(posedge clk_i);
		wr(scl_pkg::OFF_CMD, 32'h20);
		repeat (2) @(posedge clk_i);
		`CHK("count enable", 1'b0, count_en)
		rd_chk(scl_pkg::OFF_STATUS, 32'h0, "status stopped");
		gate_lvl <= 1'b0;
		repeat (5) @(posedge clk_i);
		`CHK("records", 0, rec_a.size())
		next_test("stop");
		// duration range and address clamp
		wr(scl_pkg::OFF_ON, 32'hFFFFFFFF);
		rd_chk(scl_pkg::OFF_ON, 32'hFFFFFFFF, "on max");
		wr(scl_pkg::OFF_OFF, 32'hFFFFFFFF);
		rd_chk(scl_pkg::OFF_OFF, 32'hFFFFFFFF, "off max");
		wr(scl_pkg::OFF_CUR, 32'h3FFF);
		rd_chk(scl_pkg::OFF_CUR, 32'h270F, "current clamp");
		next_test("ranges");
		report_and_stop();
	end
endmodule
`default_nettype wire
